// ===== rtl/amsw_pkg.sv
// Constants for the analog module status word block.
// Assumes a 25 MHz reference clock and a 32-bit register port.
package amsw_pkg;
    // Clock and refresh timing
    localparam int CLK_HZ = 25000000;
    localparam int REFRESH_MS = 200;
    localparam int REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
    // Input current limits in microamperes
    localparam logic [15:0] IN_LO_UA = 16'h0DAC; // 3500 uA
    localparam logic [15:0] IN_HI_UA = 16'h5014; // 20500 uA
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_SLOTS = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_LIVE = 8'h14;
    // Status word bit positions
    localparam int ST_CFG = 0;
    localparam int ST_P_LO_IN = 1;
    localparam int ST_P_HI_IN = 2;
    localparam int ST_S_LO_IN = 3;
    localparam int ST_S_HI_IN = 4;
    localparam int ST_P_LO_PR = 5;
    localparam int ST_P_HI_PR = 6;
    localparam int ST_S_LO_PR = 7;
    localparam int ST_S_HI_PR = 8;
    localparam int ST_DISC = 9;
    localparam int ST_LIM_LO = 10;
    localparam int ST_LIM_HI = 11;
    localparam int ST_IDS = 12;
    localparam int ST_MV_LSB = 16;
    // Control fields
    localparam int CT_HIDE = 0;
    localparam int CT_SRC_LSB = 1;
    localparam int CT_ANA_EN = 4;
    // Slot fields, one byte per recorder slot
    localparam int SL_EN = 7;
    localparam int MAX_CHANNELS = 4;
    // Interrupt bits
    localparam int IRQ_REFRESH = 0;
    localparam int IRQ_IDS_FALL = 1;
    localparam int IRQ_REC_REFUSED = 2;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SLOTS_RST = 32'h0000_0000;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Analog recorder sources
    typedef enum logic [2:0] {
        AMSW_SRC_PRI_FILT, AMSW_SRC_SEC_FILT, AMSW_SRC_PRI_DLY,
        AMSW_SRC_CONS, AMSW_SRC_PRI_RAW, AMSW_SRC_SEC_RAW
    } amsw_src_t;
endpackage

// ===== rtl/amsw_status.sv
// Diagnostic status word builder with recorder front end.
// Assumes all inputs come from logic on ref_clk; cyc_stb is one pulse
// per processing cycle; register port is single-cycle, no wait.
//
// Function
// - Configuration-valid flag is 1 when valid, 0 when invalid.
// - Each sensor lower input flag is 0 below 3.5 mA.
// - Each sensor upper input flag is 0 above 20.5 mA.
// - Per-sensor process range flags are 0 outside active min/max.
// - Discrepancy flag is 1 without discrepancy error, else 0.
// - Consolidated-signal limit flags are 0 outside active min/max.
// - Consolidated scaled value sits in a 16-bit unsigned field.
// - Input data status is 1 only if signals valid, no discrepancy.
// - Measured value stays available to gateways from the first refresh after hide clears.
// - Recorder takes exactly one analog value from six sources.
// - Recorder also takes logic inputs, outputs and diagnostic bits.
// - Recorder never runs more than four channels at once.
// - Published status word refreshes about every 200 ms.
// - Hide option forces status bits 16 to 31 to one.
`timescale 1ns/10ps
`default_nettype none
module amsw_status
    import amsw_pkg::*;
#(
    parameter int REFRESH_CYCLES = REFRESH_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic cyc_stb,
    input wire logic cfg_valid,
    input wire logic sensors_valid,
    input wire logic disc_err,
    input wire logic [15:0] primary_sensor_input_ua,
    input wire logic [15:0] secondary_sensor_input_ua,
    input wire logic [15:0] primary_sensor_input_filt,
    input wire logic [15:0] secondary_sensor_input_filt,
    input wire logic [15:0] primary_sensor_input_dly,
    input wire logic [15:0] primary_sensor_input_raw,
    input wire logic [15:0] secondary_sensor_input_raw,
    input wire logic [15:0] cons_value,
    input wire logic [15:0] proc_min,
    input wire logic [15:0] proc_max,
    input wire logic [15:0] logic_bits,
    output logic [31:0] status_word,
    output logic rec_stb,
    output logic [15:0] rec_analog,
    output logic rec_analog_en,
    output logic [3:0] rec_bits,
    output logic [3:0] rec_bits_en
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Flag is 1 while value is not below the lower bound
    function automatic logic ok_lo(input logic [15:0] v, input logic [15:0] b);
        return v >= b;
    endfunction

    // Flag is 1 while value does not exceed the upper bound
    function automatic logic ok_hi(input logic [15:0] v, input logic [15:0] b);
        return v <= b;
    endfunction

    // Channels in use for a given analog enable and slot setting
    function automatic logic [2:0] chan_count(input logic ana,
                                              input logic [31:0] sl);
        logic [2:0] n;
        n = {2'h0, ana};
        for (int i = 0; i < 4; i++) begin
            n = n + {2'h0, sl[8*i+SL_EN]};
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-cycle snapshot of all flags

    logic [31:0] live_reg, live_next;
    logic [31:0] live_calc;
    logic ids_fall;

    // Flag word computed from the current inputs
    always_comb begin
        live_calc = 32'h0000_0000;
        live_calc[ST_CFG] = cfg_valid;
        live_calc[ST_P_LO_IN] = ok_lo(primary_sensor_input_ua, IN_LO_UA);
        live_calc[ST_S_LO_IN] = ok_lo(secondary_sensor_input_ua, IN_LO_UA);
        live_calc[ST_P_HI_IN] = ok_hi(primary_sensor_input_ua, IN_HI_UA);
        live_calc[ST_S_HI_IN] = ok_hi(secondary_sensor_input_ua, IN_HI_UA);
        live_calc[ST_P_LO_PR] = ok_lo(primary_sensor_input_filt, proc_min);
        live_calc[ST_P_HI_PR] = ok_hi(primary_sensor_input_filt, proc_max);
        live_calc[ST_S_LO_PR] = ok_lo(secondary_sensor_input_filt, proc_min);
        live_calc[ST_S_HI_PR] = ok_hi(secondary_sensor_input_filt, proc_max);
        live_calc[ST_DISC] = !disc_err;
        live_calc[ST_LIM_LO] = ok_lo(cons_value, proc_min);
        live_calc[ST_LIM_HI] = ok_hi(cons_value, proc_max);
        live_calc[ST_IDS] = sensors_valid && !disc_err;
        live_calc[31:ST_MV_LSB] = cons_value;
    end

    // Whole word taken at once on the processing strobe
    always_comb begin
        live_next = cyc_stb ? live_calc : live_reg;
        ids_fall = cyc_stb && live_reg[ST_IDS] && !live_calc[ST_IDS];
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            live_reg <= STATUS_RST;
        end else begin
            live_reg <= live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refresh divider and published word

    logic [22:0] ref_cnt_reg, ref_cnt_next;
    logic [31:0] status_reg, status_next;
    logic ref_tick;
    logic [31:0] ctrl_reg;

    // Divider gives one tick per refresh interval; hide forces upper half
    always_comb begin
        ref_tick = (ref_cnt_reg == 23'(REFRESH_CYCLES - 1));
        ref_cnt_next = ref_tick ? 23'h000000 : ref_cnt_reg + 23'h000001;
        status_next = ref_tick ? live_reg : status_reg;
        if (ctrl_reg[CT_HIDE]) begin
            status_next[31:ST_MV_LSB] = 16'hFFFF;
        end else if (!ref_tick) begin
            status_next[31:ST_MV_LSB] = status_reg[31:ST_MV_LSB];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ref_cnt_reg <= 23'h000000;
            status_reg <= STATUS_RST;
        end else begin
            ref_cnt_reg <= ref_cnt_next;
            status_reg <= status_next;
        end
    end

    // Published word is always driven toward gateways
    assign status_word = status_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register port, configuration and interrupts

    logic [31:0] ctrl_next, slots_reg, slots_next, rdata_reg, rdata_next;
    logic [2:0] istat_reg, istat_next, imask_reg, imask_next;
    logic irq_reg, irq_next, refused;
    logic wr_ctrl, wr_slots;

    always_comb begin
        wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
        wr_slots = reg_wr && reg_addr == OFF_SLOTS;
        ctrl_next = ctrl_reg;
        slots_next = slots_reg;
        refused = 1'b0;
        // Configuration is refused if it asks for too many channels
        if (wr_ctrl) begin
            if (chan_count(reg_wdata[CT_ANA_EN], slots_reg) <= MAX_CHANNELS
                && reg_wdata[3:1] <= 3'(AMSW_SRC_SEC_RAW)) begin
                ctrl_next = {27'h0000000, reg_wdata[4:0]};
            end else begin
                refused = 1'b1;
            end
        end
        if (wr_slots) begin
            if (chan_count(ctrl_reg[CT_ANA_EN], reg_wdata & 32'h9F9F_9F9F)
                <= MAX_CHANNELS) begin
                slots_next = reg_wdata & 32'h9F9F_9F9F;
            end else begin
                refused = 1'b1;
            end
        end
        // Sticky events; a new event wins over a clearing write
        istat_next = istat_reg;
        if (reg_wr && reg_addr == OFF_IRQ_STAT) begin
            istat_next = istat_reg & ~reg_wdata[2:0];
        end
        istat_next[IRQ_REFRESH] = istat_next[IRQ_REFRESH] | ref_tick;
        istat_next[IRQ_IDS_FALL] = istat_next[IRQ_IDS_FALL] | ids_fall;
        istat_next[IRQ_REC_REFUSED] = istat_next[IRQ_REC_REFUSED] | refused;
        imask_next = (reg_wr && reg_addr == OFF_IRQ_MASK) ?
                     reg_wdata[2:0] : imask_reg;
        irq_next = |(istat_next & imask_next);
        // Read data stands in the cycle after the strobe only
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_STATUS: rdata_next = status_reg;
                OFF_CTRL: rdata_next = ctrl_reg;
                OFF_SLOTS: rdata_next = slots_reg;
                OFF_IRQ_STAT: rdata_next = {29'h0000000, istat_reg};
                OFF_IRQ_MASK: rdata_next = {29'h0000000, imask_reg};
                OFF_LIVE: rdata_next = live_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RST;
            slots_reg <= SLOTS_RST;
            istat_reg <= IRQ_RST;
            imask_reg <= IRQ_RST;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            slots_reg <= slots_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Recorder front end

    logic rec_stb_reg, rec_stb_next, rec_aen_reg, rec_aen_next;
    logic [15:0] rec_ana_reg, rec_ana_next;
    logic [3:0] rec_bits_reg, rec_bits_next, rec_ben_reg, rec_ben_next;
    logic [31:0] pool;

    // One analog source, up to four channels, sampled per cycle
    always_comb begin
        pool = {logic_bits, live_reg[15:0]};
        rec_stb_next = cyc_stb;
        rec_aen_next = ctrl_reg[CT_ANA_EN];
        rec_ben_next = rec_ben_reg;
        rec_ana_next = rec_ana_reg;
        rec_bits_next = rec_bits_reg;
        if (cyc_stb) begin
            unique case (amsw_src_t'(ctrl_reg[3:1]))
                AMSW_SRC_PRI_FILT: rec_ana_next = primary_sensor_input_filt;
                AMSW_SRC_SEC_FILT: rec_ana_next = secondary_sensor_input_filt;
                AMSW_SRC_PRI_DLY: rec_ana_next = primary_sensor_input_dly;
                AMSW_SRC_CONS: rec_ana_next = cons_value;
                AMSW_SRC_PRI_RAW: rec_ana_next = primary_sensor_input_raw;
                AMSW_SRC_SEC_RAW: rec_ana_next = secondary_sensor_input_raw;
                default: rec_ana_next = 16'h0000;
            endcase
            for (int i = 0; i < 4; i++) begin
                rec_ben_next[i] = slots_reg[8*i+SL_EN];
                rec_bits_next[i] = slots_reg[8*i+SL_EN] &
                                   pool[slots_reg[8*i +: 5]];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rec_stb_reg <= 1'b0;
            rec_aen_reg <= 1'b0;
            rec_ana_reg <= 16'h0000;
            rec_bits_reg <= 4'h0;
            rec_ben_reg <= 4'h0;
        end else begin
            rec_stb_reg <= rec_stb_next;
            rec_aen_reg <= rec_aen_next;
            rec_ana_reg <= rec_ana_next;
            rec_bits_reg <= rec_bits_next;
            rec_ben_reg <= rec_ben_next;
        end
    end

    assign rec_stb = rec_stb_reg;
    assign rec_analog = rec_ana_reg;
    assign rec_analog_en = rec_aen_reg;
    assign rec_bits = rec_bits_reg;
    assign rec_bits_en = rec_ben_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_cfg;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb |=> live_reg[ST_CFG] == $past(cfg_valid);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg flag wrong");

    property p_lo_in;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb && primary_sensor_input_ua < IN_LO_UA |=> !live_reg[ST_P_LO_IN];
    endproperty
    a_lo_in: assert property (p_lo_in) else $error("low input flag");

    property p_hi_in;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb && secondary_sensor_input_ua > IN_HI_UA
        |=> !live_reg[ST_S_HI_IN];
    endproperty
    a_hi_in: assert property (p_hi_in) else $error("high input flag");

    property p_disc;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb && disc_err |=> !live_reg[ST_DISC] && !live_reg[ST_IDS];
    endproperty
    a_disc: assert property (p_disc) else $error("discrepancy flag");

    property p_ids;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb && sensors_valid && !disc_err |=> live_reg[ST_IDS];
    endproperty
    a_ids: assert property (p_ids) else $error("input data status");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !cyc_stb |=> $stable(live_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved");

    property p_hide;
        @(posedge ref_clk) disable iff (!resetn)
        ctrl_reg[CT_HIDE] |=> status_word[31:16] == 16'hFFFF;
    endproperty
    a_hide: assert property (p_hide) else $error("hide failed");

    property p_refresh;
        @(posedge ref_clk) disable iff (!resetn)
        ref_tick && !ctrl_reg[CT_HIDE] |=> status_word == $past(live_reg);
    endproperty
    a_refresh: assert property (p_refresh) else $error("no refresh");

    property p_chan;
        @(posedge ref_clk) disable iff (!resetn)
        rec_stb |-> ({2'h0, rec_analog_en} + {2'h0, rec_bits_en[0]}
            + {2'h0, rec_bits_en[1]} + {2'h0, rec_bits_en[2]}
            + {2'h0, rec_bits_en[3]}) <= 3'h4;
    endproperty
    a_chan: assert property (p_chan) else $error("too many channels");

    property p_cons;
        @(posedge ref_clk) disable iff (!resetn)
        cyc_stb |=> live_reg[31:16] == $past(cons_value);
    endproperty
    a_cons: assert property (p_cons) else $error("measured value");

    c_refresh: cover property (@(posedge ref_clk) disable iff (!resetn)
        ref_tick ##1 irq);
    c_refused: cover property (@(posedge ref_clk) disable iff (!resetn)
        refused);
    c_ids_fall: cover property (@(posedge ref_clk) disable iff (!resetn)
        ids_fall);

endmodule // amsw_status
`default_nettype wire

// ===== verif/amsw_consumer.sv
// Model of the controller side that reads the published status word.
// Assumes status_word is stable between refreshes on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module amsw_consumer #(
    parameter int GRADIENT = 5000,
    parameter int OFFSET = 16
) (
    input wire logic ref_clk,
    input wire logic [31:0] status_word,
    output logic [31:0] sensor_val
);
    ////////////////////////////////////////////////////////////////////////
    // Converts the measured value every cycle with the primary gradient
    always @(posedge ref_clk) begin
        sensor_val <= 32'(status_word[31:16]) * GRADIENT / 2500
            + OFFSET;
    end
endmodule // amsw_consumer
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the status word block and its recorder.
// Assumes one 25 MHz clock and a shortened refresh period.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import amsw_pkg::*;
    localparam int REF = 20;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, cyc_stb = 1'b0;
    logic cfg_valid = 1'b1, sensors_valid = 1'b1, disc_err = 1'b0;
    logic [15:0] pua = 16'h2710, sua = 16'h2710, pf = 16'h01F4;
    logic [15:0] sf = 16'h01F4, pd = 16'h0033, pr = 16'h0044;
    logic [15:0] sr = 16'h0055, cons = 16'h01F4, lbits = 16'hA5C3;
    logic [15:0] pmin = 16'h0064, pmax = 16'h0384;
    logic [31:0] reg_rdata, status_word, sensor_val, d;
    logic irq, rec_stb, rec_analog_en;
    logic [15:0] rec_analog;
    logic [3:0] rec_bits, rec_bits_en;
    int n_fail = 0, tests_run = 0, cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design, far-side reader and clock
    amsw_status #(.REFRESH_CYCLES(REF)) dut (.ref_clk(ref_clk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .cyc_stb(cyc_stb), .cfg_valid(cfg_valid),
        .sensors_valid(sensors_valid), .disc_err(disc_err),
        .primary_sensor_input_ua(pua), .secondary_sensor_input_ua(sua),
        .primary_sensor_input_filt(pf), .secondary_sensor_input_filt(sf),
        .primary_sensor_input_dly(pd), .primary_sensor_input_raw(pr),
        .secondary_sensor_input_raw(sr), .cons_value(cons),
        .proc_min(pmin), .proc_max(pmax), .logic_bits(lbits),
        .status_word(status_word), .rec_stb(rec_stb),
        .rec_analog(rec_analog), .rec_analog_en(rec_analog_en),
        .rec_bits(rec_bits), .rec_bits_en(rec_bits_en));
    amsw_consumer cons_model (.ref_clk(ref_clk), .status_word(status_word),
        .sensor_val(sensor_val));
    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // Verdict, compare and bus tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One processing cycle strobe; recorder answers next cycle
    task automatic cyc();
        @(posedge ref_clk);
        cyc_stb <= 1'b1;
        @(posedge ref_clk);
        cyc_stb <= 1'b0;
        #1 chk(32'(rec_stb), 32'h1);
    endtask
    task automatic set_in(input logic c, s, e, input logic [15:0] a, b,
        input logic [15:0] f, g, n);
        @(posedge ref_clk);
        cfg_valid <= c;
        sensors_valid <= s;
        disc_err <= e;
        pua <= a;
        sua <= b;
        pf <= f;
        sf <= g;
        cons <= n;
    endtask
    // Status word worked out from the current inputs
    function automatic logic [31:0] exp_st();
        logic [31:0] e;
        e = 32'h0;
        e[ST_CFG] = cfg_valid;
        e[ST_P_LO_IN] = !(pua < IN_LO_UA);
        e[ST_P_HI_IN] = !(pua > IN_HI_UA);
        e[ST_S_LO_IN] = !(sua < IN_LO_UA);
        e[ST_S_HI_IN] = !(sua > IN_HI_UA);
        e[ST_P_LO_PR] = !(pf < pmin);
        e[ST_P_HI_PR] = !(pf > pmax);
        e[ST_S_LO_PR] = !(sf < pmin);
        e[ST_S_HI_PR] = !(sf > pmax);
        e[ST_DISC] = !disc_err;
        e[ST_LIM_LO] = !(cons < pmin);
        e[ST_LIM_HI] = !(cons > pmax);
        e[ST_IDS] = sensors_valid && !disc_err;
        e[31:16] = cons;
        return e;
    endfunction
    function automatic logic [15:0] src_val(input int k);
        case (k)
            0: return pf;
            1: return sf;
            2: return pd;
            3: return cons;
            4: return pr;
            default: return sr;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 0; a <= 8'h14; a += 4) begin
            rd(8'(a));
            chk(d, 32'h0);
        end
        rd(8'h20);
        chk(d, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test reset and map done");
        // Flag cases: nominal, below/above limits, exact bounds
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: set_in(1, 1, 0, 16'h2710, 16'h2710, 16'h01F4, 16'h01F4,
                    16'h01F4);
                1: set_in(0, 1, 1, 16'h0DAB, 16'h5015, 16'h0063, 16'h0385,
                    16'h0063);
                2: set_in(1, 0, 0, 16'h0DAC, 16'h5014, 16'h0064, 16'h0384,
                    16'h0385);
                default: set_in(1, 1, 0, 16'h5015, 16'h0DAB, 16'h0385,
                    16'h0063, 16'h0384);
            endcase
            cyc();
            rd(OFF_LIVE);
            chk(d, exp_st());
            chk(d, exp_st());
        end
        $display("test flags done");
        set_in(1, 1, 0, 16'h2710, 16'h2710, 16'h01F4, 16'h01F4, 16'h01F4);
        cyc();
        // Clear the refresh event so the next tick must set it again
        wr(OFF_IRQ_STAT, 32'h1);
        repeat (REF + 2) @(posedge ref_clk);
        #1 chk(status_word, exp_st());
        chk(sensor_val, 32'h3F8);
        rd(OFF_IRQ_STAT);
        chk(d & 32'h1, 32'h1);
        $display("test refresh done");
        wr(OFF_CTRL, 32'h1);
        @(posedge ref_clk);
        #1 chk(32'(status_word[31:16]), 32'hFFFF);
        chk(32'(status_word[15:0]), 32'(exp_st() & 32'hFFFF));
        wr(OFF_CTRL, 32'h0);
        $display("test hide done");
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (REF + 2) @(posedge ref_clk);
        #1 chk(32'(irq), 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(irq), 32'h0);
        // Earlier flag cases left this event set; start from a clean bit
        wr(OFF_IRQ_STAT, 32'h2);
        sensors_valid <= 1'b0;
        cyc();
        rd(OFF_IRQ_STAT);
        chk(d & 32'h2, 32'h2);
        wr(OFF_IRQ_STAT, 32'h2);
        rd(OFF_IRQ_STAT);
        chk(d & 32'h2, 32'h0);
        $display("test interrupt done");
        // Four bit slots fill the channel budget
        // Slot 0 picks live bit 13, which always reads zero
        wr(OFF_SLOTS, 32'hF3F2F18D);
        rd(OFF_SLOTS);
        chk(d, 32'h9392918D);
        cyc();
        chk(32'(rec_bits), 32'({lbits[3:1], 1'b0}));
        chk(32'(rec_bits_en), 32'hF);
        wr(OFF_CTRL, 32'h10);
        rd(OFF_CTRL);
        chk(d, 32'h0);
        rd(OFF_IRQ_STAT);
        chk(d & 32'h4, 32'h4);
        wr(OFF_CTRL, 32'h0C);
        rd(OFF_CTRL);
        chk(d, 32'h0);
        wr(OFF_SLOTS, 32'h0);
        // Distinct values on every recorder source
        set_in(1, 1, 0, 16'h2710, 16'h2710, 16'h0011, 16'h0022, 16'h01F4);
        for (int k = 0; k < 6; k++) begin
            wr(OFF_CTRL, 32'h10 | 32'(k << 1));
            cyc();
            chk(32'(rec_analog), 32'(src_val(k)));
            chk(32'(rec_analog_en), 32'h1);
        end
        $display("test recorder done");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
